// file: design/isrf_framer.sv
// Our own choices: the register offsets and the APB interface to the registers.
`include "isrf_regs.svh"
module isrf_framer
	import isrf_pkg::*;
#(
	parameter int DEPTH = 16
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [127:0] AOUT_CODES,
	input wire logic [127:0] AIN_RAW,
	input wire logic [15:0] DOUT_STATE,
	input wire logic [15:0] DIN_PINS,
	input wire logic [31:0] PULSE_COUNT,
	output logic [7:0] TX_DATA,
	output logic TX_VALID,
	input wire logic TX_READY,
	output logic TX_LAST,
	output logic TX_PERIODIC
);
	localparam int NCH = 8;
	localparam int NB = `ISRF_REC_BYTES;
	localparam logic [5:0] IDX_LAST = 6'(NB - 1);
	localparam logic [15:0] REC_LEN = 16'(NB);
	localparam logic [6:0] TICK_LAST = 7'(`ISRF_TICK_CYC - 1);

	function automatic logic reg_hit(input logic [7:0] a);
		case (a)
			`ISRF_CTRL_OFS, `ISRF_PERIOD_OFS, `ISRF_GEN_OFS, `ISRF_UVA_OFS,
			`ISRF_UVB_OFS, `ISRF_RANGE_OFS, `ISRF_SAMPLE_OFS, `ISRF_COUNT_OFS: begin
				reg_hit = 1'b1;
			end
			default: begin
				reg_hit = 1'b0;
			end
		endcase
	endfunction

	logic [15:0] din_m_r, din_s_r;
	logic push_en_r, push_en_nxt, var_cfg_r, var_cfg_nxt;
	logic qpend_r, qpend_nxt, ppend_r, ppend_nxt;
	logic [31:0] period_r, period_nxt;
	logic [15:0] gen_r, gen_nxt;
	logic [31:0] uva_r, uva_nxt, uvb_r, uvb_nxt;
	logic [23:0] range_r, range_nxt;
	logic [15:0] sample_r, sample_nxt;
	logic [31:0] count_r, count_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic [6:0] tick_r, tick_nxt;
	logic [31:0] per_r, per_nxt;
	isrf_state_t state_r, state_nxt;
	logic [5:0] idx_r, idx_nxt;
	logic kind_r, kind_nxt;
	logic [7:0] snap_r [0:NB-1];
	logic [7:0] snap_nxt [0:NB-1];
	logic [127:0] ai_cnt, ao_cnt;
	logic [8*NB-1:0] cap_vec;
	logic wr_en, q_set, p_set, tick, capture, take_q, take_p;
	logic fin_valid, fin_ready, wr_push;
	logic [9:0] fin_data, fout_data;

	// Input pins are asynchronous to the core clock
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			din_m_r <= 16'h0000;
			din_s_r <= 16'h0000;
		end else begin
			din_m_r <= DIN_PINS;
			din_s_r <= din_m_r;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			isrf_enc u_enc (
				.var_cfg(var_cfg_r),
				.mode(range_r[3*g +: 3]),
				.ain_raw(AIN_RAW[16*g +: 16]),
				.aout_code(AOUT_CODES[16*g +: 16]),
				.ain_cnt(ai_cnt[16*g +: 16]),
				.aout_cnt(ao_cnt[16*g +: 16])
			);
		end
	endgenerate

	// Register bus: zero wait states, read data staged in the setup cycle
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~reg_hit(PADDR);
	assign PRDATA = prdata_r;
	assign wr_en = PSEL & PENABLE & PWRITE & reg_hit(PADDR);
	assign q_set = wr_en && PADDR == `ISRF_CTRL_OFS && PWDATA[`ISRF_CTRL_QUERY];

	always_comb begin
		push_en_nxt = push_en_r;
		var_cfg_nxt = var_cfg_r;
		period_nxt = period_r;
		gen_nxt = gen_r;
		uva_nxt = uva_r;
		uvb_nxt = uvb_r;
		range_nxt = range_r;
		prdata_nxt = prdata_r;
		if (wr_en) begin
			case (PADDR)
				`ISRF_CTRL_OFS: begin
					push_en_nxt = PWDATA[`ISRF_CTRL_PUSH];
					var_cfg_nxt = PWDATA[`ISRF_CTRL_VAR];
				end
				`ISRF_PERIOD_OFS: begin
					period_nxt = PWDATA;
				end
				`ISRF_GEN_OFS: begin
					// Undefined status bits stay zero
					gen_nxt = {PWDATA[15:8] & `ISRF_GEN_STAT_MASK, PWDATA[7:0]};
				end
				`ISRF_UVA_OFS: begin
					uva_nxt = PWDATA;
				end
				`ISRF_UVB_OFS: begin
					uvb_nxt = PWDATA;
				end
				`ISRF_RANGE_OFS: begin
					range_nxt = PWDATA[23:0];
				end
				default: begin
				end
			endcase
		end
		if (PSEL && !PENABLE) begin
			case (PADDR)
				`ISRF_CTRL_OFS: begin
					prdata_nxt = {22'h0, qpend_r, state_r == ST_SEND, 5'h0, var_cfg_r, push_en_r, 1'b0};
				end
				`ISRF_PERIOD_OFS: begin
					prdata_nxt = period_r;
				end
				`ISRF_GEN_OFS: begin
					prdata_nxt = {16'h0, gen_r};
				end
				`ISRF_UVA_OFS: begin
					prdata_nxt = uva_r;
				end
				`ISRF_UVB_OFS: begin
					prdata_nxt = uvb_r;
				end
				`ISRF_RANGE_OFS: begin
					prdata_nxt = {8'h0, range_r};
				end
				`ISRF_SAMPLE_OFS: begin
					prdata_nxt = {16'h0, sample_r};
				end
				`ISRF_COUNT_OFS: begin
					prdata_nxt = count_r;
				end
				default: begin
					prdata_nxt = 32'h0;
				end
			endcase
		end
	end

	// Microsecond tick, then the push period counted in ticks
	assign tick = tick_r == TICK_LAST;

	always_comb begin
		tick_nxt = tick ? 7'h00 : tick_r + 7'h01;
		per_nxt = per_r;
		p_set = 1'b0;
		if (!push_en_r) begin
			per_nxt = 32'h0;
		end else if (tick) begin
			// A zero period behaves as one tick
			if (per_r + 32'h1 >= period_r) begin
				per_nxt = 32'h0;
				p_set = 1'b1;
			end else begin
				per_nxt = per_r + 32'h1;
			end
		end
	end

	// Queries win over periodic pushes when both wait
	assign capture = state_r == ST_IDLE && (qpend_r || ppend_r);
	assign take_q = capture & qpend_r;
	assign take_p = capture & ~qpend_r;

	always_comb begin
		// A request arriving as its flag is consumed is kept
		qpend_nxt = q_set | (qpend_r & ~take_q);
		ppend_nxt = p_set | (ppend_r & ~take_p);
	end

	// Whole record frozen in one cycle so fields agree
	assign cap_vec = {uvb_r, uva_r, PULSE_COUNT, din_s_r, DOUT_STATE, ai_cnt, ao_cnt,
		gen_r[15:8], gen_r[7:0], sample_r + 16'h1, REC_LEN, `ISRF_HDR_WORD};

	always_comb begin
		sample_nxt = sample_r;
		for (int i = 0; i < NB; i++) begin
			snap_nxt[i] = snap_r[i];
		end
		if (capture) begin
			sample_nxt = sample_r + 16'h1;
			for (int i = 0; i < NB; i++) begin
				snap_nxt[i] = cap_vec[8*i +: 8];
			end
		end
	end

	// Serialiser feeds the FIFO and stalls when it is full
	assign fin_valid = state_r == ST_SEND;
	assign fin_data = {kind_r, idx_r == IDX_LAST, snap_r[idx_r]};
	assign wr_push = fin_valid & fin_ready;

	always_comb begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		kind_nxt = kind_r;
		count_nxt = count_r;
		case (state_r)
			ST_IDLE: begin
				if (capture) begin
					state_nxt = ST_SEND;
					idx_nxt = 6'h00;
					kind_nxt = ~qpend_r;
				end
			end
			ST_SEND: begin
				if (wr_push) begin
					if (idx_r == IDX_LAST) begin
						state_nxt = ST_IDLE;
						count_nxt = count_r + 32'h1;
					end else begin
						idx_nxt = idx_r + 6'h01;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			push_en_r <= 1'b0;
			var_cfg_r <= 1'b1;
			qpend_r <= 1'b0;
			ppend_r <= 1'b0;
			period_r <= `ISRF_PERIOD_RST;
			gen_r <= 16'h0000;
			uva_r <= 32'h0;
			uvb_r <= 32'h0;
			range_r <= `ISRF_RANGE_RST;
			sample_r <= 16'h0000;
			count_r <= 32'h0;
			prdata_r <= 32'h0;
			tick_r <= 7'h00;
			per_r <= 32'h0;
			state_r <= ST_IDLE;
			idx_r <= 6'h00;
			kind_r <= 1'b0;
			for (int i = 0; i < NB; i++) begin
				snap_r[i] <= 8'h00;
			end
		end else begin
			push_en_r <= push_en_nxt;
			var_cfg_r <= var_cfg_nxt;
			qpend_r <= qpend_nxt;
			ppend_r <= ppend_nxt;
			period_r <= period_nxt;
			gen_r <= gen_nxt;
			uva_r <= uva_nxt;
			uvb_r <= uvb_nxt;
			range_r <= range_nxt;
			sample_r <= sample_nxt;
			count_r <= count_nxt;
			prdata_r <= prdata_nxt;
			tick_r <= tick_nxt;
			per_r <= per_nxt;
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			kind_r <= kind_nxt;
			for (int i = 0; i < NB; i++) begin
				snap_r[i] <= snap_nxt[i];
			end
		end
	end

	isrf_fifo #(
		.DW(10),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.in_valid(fin_valid),
		.in_ready(fin_ready),
		.in_data(fin_data),
		.out_valid(TX_VALID),
		.out_ready(TX_READY),
		.out_data(fout_data)
	);

	assign TX_DATA = fout_data[7:0];
	assign TX_LAST = fout_data[8];
	assign TX_PERIODIC = fout_data[9];

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (SYS_RST);

	property p_start;
		capture |=> state_r == ST_SEND && idx_r == 6'h00;
	endproperty
	a_start: assert property (p_start) else $error("record did not start at byte 0");

	property p_hdr_mark;
		wr_push && idx_r == 6'h01 |-> fin_data[7];
	endproperty
	a_hdr_mark: assert property (p_hdr_mark) else $error("header bit 15 clear");

	property p_len;
		wr_push && (idx_r == 6'h02 || idx_r == 6'h03) |->
			fin_data[7:0] == (idx_r[0] ? REC_LEN[15:8] : REC_LEN[7:0]);
	endproperty
	a_len: assert property (p_len) else $error("header length wrong");

	property p_sample_lo;
		wr_push && idx_r == 6'h04 |-> fin_data[7:0] == sample_r[7:0];
	endproperty
	a_sample_lo: assert property (p_sample_lo) else $error("sample number not low byte first");

	property p_sample_inc;
		capture |=> sample_r == $past(sample_r) + 16'h1;
	endproperty
	a_sample_inc: assert property (p_sample_inc) else $error("sample number did not step");

	property p_gstat;
		wr_push && idx_r == 6'h07 |-> fin_data[6:3] == 4'h0;
	endproperty
	a_gstat: assert property (p_gstat) else $error("undefined status bits set");

	property p_end;
		wr_push && idx_r == IDX_LAST |-> fin_data[8] ##1 state_r == ST_IDLE;
	endproperty
	a_end: assert property (p_end) else $error("record did not end after last byte");

	property p_query_once;
		take_q && !q_set |=> !qpend_r;
	endproperty
	a_query_once: assert property (p_query_once) else $error("query answered twice");

	property p_ain12;
		!var_cfg_r |-> ai_cnt[15:0] <= 16'h7ff0 && ao_cnt[3:0] == 4'h0;
	endproperty
	a_ain12: assert property (p_ain12) else $error("12-bit counts out of span");

	property p_ain_sgn;
		var_cfg_r && range_r[2:0] == `ISRF_AIN_BIP5 |-> ai_cnt[15:0] == (AIN_RAW[15:0] ^ 16'h8000);
	endproperty
	a_ain_sgn: assert property (p_ain_sgn) else $error("bipolar count not signed");

	c_query: cover property (capture && qpend_r);
	c_push: cover property (capture && !qpend_r);
	c_stall: cover property (fin_valid && !fin_ready);
	c_both: cover property (qpend_r && ppend_r);
endmodule // isrf_framer

// file: design/isrf_regs.svh
`ifndef ISRF_REGS_SVH
`define ISRF_REGS_SVH
// Behaviour
// - A query sends one snapshot record; periodic push resends it on its own handle
// - Every record starts with a four-byte header, then the whole body
// - Body: sample number word, error byte, status byte, analog outputs 0..7
// - Then analog inputs 0..7, output word, input word, pulse long, two signed longs
// - Words go out little-endian, low byte first; longs are four bytes
// - Header bytes 0 and 1 as a word have bit 15 set
// - Header bytes 2 and 3 hold total record length, low byte first
// - Status byte: bit 7 running, bit 2 waiting, bit 1 trace, bit 0 echo
// - Configurable variant: analog input words are signed for bipolar ranges, unsigned for unipolar
// - 12-bit variant: inputs span 0..0x7FF0, outputs 0..0xFFF0
// - Configurable variant: modes 1,2 signed, modes 3,4 unsigned; outputs full range
// - Last two longs carry user variable a, then user variable b
`define ISRF_CTRL_OFS 8'h00
`define ISRF_PERIOD_OFS 8'h04
`define ISRF_GEN_OFS 8'h08
`define ISRF_UVA_OFS 8'h0c
`define ISRF_UVB_OFS 8'h10
`define ISRF_RANGE_OFS 8'h14
`define ISRF_SAMPLE_OFS 8'h18
`define ISRF_COUNT_OFS 8'h1c
`define ISRF_CTRL_QUERY 0
`define ISRF_CTRL_PUSH 1
`define ISRF_CTRL_VAR 2
`define ISRF_GEN_STAT_MASK 8'h87
`define ISRF_PERIOD_RST 32'h000003e8
`define ISRF_RANGE_RST 24'h6db6db
`define ISRF_HDR_WORD 16'h8000
`define ISRF_REC_BYTES 56
`define ISRF_AIN_BIP5 3'd1
`define ISRF_AIN_BIP10 3'd2
`define ISRF_TICK_NS 1000
`define ISRF_CLK_NS 10
`define ISRF_TICK_CYC (`ISRF_TICK_NS / `ISRF_CLK_NS)
`endif

// file: design/isrf_pkg.sv
package isrf_pkg;
	typedef enum logic {ST_IDLE, ST_SEND} isrf_state_t;
endpackage

// file: design/isrf_enc.sv
`include "isrf_regs.svh"
module isrf_enc (
	input wire logic var_cfg,
	input wire logic [2:0] mode,
	input wire logic [15:0] ain_raw,
	input wire logic [15:0] aout_code,
	output logic [15:0] ain_cnt,
	output logic [15:0] aout_cnt
);
	always_comb begin
		if (!var_cfg) begin
			// All input modes scale alike on this variant
			ain_cnt = {1'b0, ain_raw[11:1], 4'h0};
			aout_cnt = {aout_code[11:0], 4'h0};
		end else begin
			aout_cnt = aout_code;
			case (mode)
				`ISRF_AIN_BIP5, `ISRF_AIN_BIP10: begin
					// Converter gives offset binary; flip the top bit
					ain_cnt = ain_raw ^ 16'h8000;
				end
				default: begin
					ain_cnt = ain_raw;
				end
			endcase
		end
	end
endmodule // isrf_enc

// file: design/isrf_fifo.sv
module isrf_fifo #(
	parameter int DW = 10,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [DW-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [DW-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [DW-1:0] mem_r [0:DEPTH-1];
	logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic push, pop;

	assign in_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
	assign out_valid = wp_r != rp_r;
	assign out_data = mem_r[rp_r[AW-1:0]];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end

	// Storage needs no reset; only words behind the pointers are read
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wp_r[AW-1:0]] <= in_data;
		end
	end
endmodule // isrf_fifo

// file: tb/isrf_sink_model.sv
module isrf_sink_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic hold,
	output logic ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] pat_r;
	// Irregular stalls, so back-pressure lands mid-record
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pat_r <= 8'h5a;
			ready <= 1'b0;
		end else begin
			pat_r <= {pat_r[6:0], pat_r[7] ^ pat_r[5] ^ pat_r[4] ^ pat_r[3]};
			ready <= !hold && (pat_r[1:0] != 2'h0);
		end
	end
endmodule // isrf_sink_model

// file: tb/io_status_record_framer_test.sv
`include "isrf_regs.svh"
module io_status_record_framer_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic CORE_CLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic [127:0] AOUT_CODES = '0;
	logic [127:0] AIN_RAW = '0;
	logic [15:0] DOUT_STATE = 16'h0;
	logic [15:0] DIN_PINS = 16'h0;
	logic [31:0] PULSE_COUNT = 32'h0;
	logic [7:0] TX_DATA;
	logic TX_VALID;
	logic TX_READY;
	logic TX_LAST;
	logic TX_PERIODIC;
	logic hold = 1'b0;
	logic seen_per = 1'b0;
	int n_fail = 0;
	int n_compared = 0;
	int pos;
	logic per_r;
	logic cfg = 1'b1;
	logic [31:0] lfsr = 32'd87690;
	logic [9:0] notes[$];
	logic [31:0] va;
	logic [31:0] vb;
	logic [7:0] err;
	logic [7:0] stat;
	logic [2:0] modes[8];

	initial forever #5 CORE_CLK = ~CORE_CLK;

	isrf_framer #(.DEPTH(16)) i_dut (.CORE_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
		.PREADY, .PSLVERR, .AOUT_CODES, .AIN_RAW, .DOUT_STATE, .DIN_PINS, .PULSE_COUNT, .TX_DATA, .TX_VALID,
		.TX_READY, .TX_LAST, .TX_PERIODIC);
	isrf_sink_model i_sink (.clk(CORE_CLK), .rst(SYS_RST), .hold(hold), .ready(TX_READY));

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
		return lfsr;
	endfunction

	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e, input logic er);
		int k;
		@(posedge CORE_CLK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		k = 0;
		do begin
			@(posedge CORE_CLK);
			k++;
		end while (PREADY !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_fail++;
			complete_run();
		end
		chk("pslverr", {31'h0, PSLVERR}, {31'h0, er});
		if (!wr) chk("prdata", PRDATA, e);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
		apb(1'b0, a, 32'h0, e, er);
	endtask

	task automatic b8(input logic [7:0] v);
		notes.push_back({per_r, pos == `ISRF_REC_BYTES - 1, v});
		pos++;
	endtask

	task automatic b16(input logic [15:0] v);
		b8(v[7:0]);
		b8(v[15:8]);
	endtask

	task automatic b32(input logic [31:0] v);
		b16(v[15:0]);
		b16(v[31:16]);
	endtask

	task automatic expect_rec(input logic [15:0] smp, input logic per);
		logic [15:0] r;
		per_r = per;
		pos = 0;
		b16(`ISRF_HDR_WORD);
		b16(16'(`ISRF_REC_BYTES));
		b16(smp);
		b8(err);
		b8(stat & `ISRF_GEN_STAT_MASK);
		for (int i = 0; i < 8; i++) begin
			r = AOUT_CODES[16*i +: 16];
			b16(cfg ? r : {r[11:0], 4'h0});
		end
		for (int i = 0; i < 8; i++) begin
			r = AIN_RAW[16*i +: 16];
			if (!cfg) r = {1'b0, r[11:1], 4'h0};
			else if (modes[i] == 3'd1 || modes[i] == 3'd2) r = r ^ 16'h8000;
			b16(r);
		end
		b16(DOUT_STATE);
		b16(DIN_PINS);
		b32(PULSE_COUNT);
		b32(va);
		b32(vb);
	endtask

	task automatic set_inputs();
		@(posedge CORE_CLK);
		for (int i = 0; i < 8; i++) begin
			AOUT_CODES[16*i +: 16] <= 16'(rnd());
			AIN_RAW[16*i +: 16] <= 16'(rnd());
		end
		DOUT_STATE <= 16'(rnd());
		DIN_PINS <= 16'(rnd());
		PULSE_COUNT <= rnd();
		@(posedge CORE_CLK);
	endtask

	task automatic set_regs();
		va = rnd();
		vb = rnd();
		err = 8'(rnd());
		// Undefined status bits forced on so masking shows
		stat = 8'(rnd()) | 8'h78;
		wr(`ISRF_UVA_OFS, va);
		wr(`ISRF_UVB_OFS, vb);
		wr(`ISRF_GEN_OFS, {16'h0, stat, err});
		rd(`ISRF_GEN_OFS, {16'h0, stat & `ISRF_GEN_STAT_MASK, err}, 1'b0);
	endtask

	task automatic drain();
		int k;
		k = 0;
		while ((notes.size() != 0 || TX_VALID !== 1'b0) && k < 3000) begin
			@(posedge CORE_CLK);
			k++;
		end
		if (k >= 3000) begin
			n_fail++;
			complete_run();
		end
	endtask

	always @(posedge CORE_CLK) begin
		if (!SYS_RST && TX_VALID === 1'b1 && TX_READY === 1'b1) begin
			if (TX_PERIODIC === 1'b1) seen_per <= 1'b1;
			if (notes.size() == 0) chk("stray byte", 32'h1, 32'h0);
			else chk("record byte", {22'h0, TX_PERIODIC, TX_LAST, TX_DATA}, {22'h0, notes.pop_front()});
		end
	end

	initial begin
		int k;
		logic [23:0] rng;
		for (int i = 0; i < 8; i++) modes[i] = 3'd3;
		repeat (12) @(posedge CORE_CLK);
		SYS_RST <= 1'b0;
		rd(`ISRF_CTRL_OFS, 32'h4, 1'b0);
		rd(`ISRF_PERIOD_OFS, `ISRF_PERIOD_RST, 1'b0);
		rd(`ISRF_RANGE_OFS, {8'h00, `ISRF_RANGE_RST}, 1'b0);
		rd(`ISRF_SAMPLE_OFS, 32'h0, 1'b0);
		rd(8'h20, 32'h0, 1'b1);
		apb(1'b1, 8'h24, 32'hffffffff, 32'h0, 1'b1);
		$display("test reset_regs done");
		for (int i = 0; i < 8; i++) modes[i] = 3'(i % 4 + 1);
		for (int i = 0; i < 8; i++) rng[3*i +: 3] = modes[i];
		wr(`ISRF_RANGE_OFS, {8'h00, rng});
		set_regs();
		set_inputs();
		// Sink held off long enough to fill the buffer
		hold <= 1'b1;
		expect_rec(16'd1, 1'b0);
		wr(`ISRF_CTRL_OFS, 32'h5);
		repeat (60) @(posedge CORE_CLK);
		rd(`ISRF_CTRL_OFS, 32'h104, 1'b0);
		hold <= 1'b0;
		drain();
		$display("test query_full_buffer done");
		cfg = 1'b0;
		set_regs();
		set_inputs();
		expect_rec(16'd2, 1'b0);
		expect_rec(16'd3, 1'b0);
		wr(`ISRF_CTRL_OFS, 32'h1);
		wr(`ISRF_CTRL_OFS, 32'h1);
		drain();
		rd(`ISRF_COUNT_OFS, 32'd3, 1'b0);
		$display("test twelve_bit_back_to_back done");
		cfg = 1'b1;
		wr(`ISRF_PERIOD_OFS, 32'h1);
		expect_rec(16'd4, 1'b1);
		wr(`ISRF_CTRL_OFS, 32'h6);
		k = 0;
		while (!seen_per && k < 500) begin
			@(posedge CORE_CLK);
			k++;
		end
		if (k >= 500) begin
			n_fail++;
			complete_run();
		end
		wr(`ISRF_CTRL_OFS, 32'h4);
		drain();
		rd(`ISRF_SAMPLE_OFS, 32'd4, 1'b0);
		$display("test periodic_push done");
		complete_run();
	end
endmodule // io_status_record_framer_test
